// ==== rtl/aprs_pkg.sv ====
// package of constants and types for the power rail sequencer
package aprs_pkg;
  // register offsets
  localparam logic [15:0] OFF_PG_DELAY = 16'h0af5;
  localparam logic [15:0] OFF_RAIL_CTRL = 16'h0af7;
  // power good delay select fields
  localparam int PGD_MAIN_LSB = 0;
  localparam int PGD_EXTRA_LSB = 2;
  localparam int PGD_RESET_CONTROL_OUT_N_BIT = 4;
  localparam int PGD_LOSS_LSB = 5;
  localparam logic [7:0] PGD_RESET = 8'h03;
  // rail sequence control fields
  localparam int RSC_CORE_ON_S3 = 0;
  localparam int RSC_LINK_ON_S3 = 1;
  localparam int RSC_KEEP_CUT0 = 2;
  localparam int RSC_KEEP_CUT1 = 3;
  localparam int RSC_LAST_ON = 4;
  localparam logic [7:0] RSC_RESET = 8'h00;
  // after-loss modes
  localparam logic [1:0] LOSS_OFF = 2'h0;
  localparam logic [1:0] LOSS_ON = 2'h1;
  localparam logic [1:0] LOSS_KEEP = 2'h2;
  // timing, slow clock period and derived counts
  localparam int CLK_NS = 10;
  localparam int STEP_MS = 100;
  localparam int STEP_CYC = (STEP_MS * 1000000) / CLK_NS;
  localparam int STEP_W = 24;
  // power states
  typedef enum logic [4:0] {
    ST_S5 = 5'h01,
    ST_S3T = 5'h02,
    ST_S0 = 5'h04,
    ST_S3 = 5'h08,
    ST_DSW = 5'h10
  } aprs_state_t;
endpackage : aprs_pkg

// ==== rtl/aprs_tick_if.sv ====
// tick carrier between the sequencer and its 100 ms step timer
`timescale 1ns/100ps
interface aprs_tick_if;
  logic tick; // one-cycle pulse every delay step
  modport src (output tick);
  modport dst (input tick);
endinterface : aprs_tick_if

// ==== rtl/aprs_tick.sv ====
// free-running step timer producing one tick per 100 ms
`timescale 1ns/100ps
module aprs_tick #(
  parameter int STEP_CYC = aprs_pkg::STEP_CYC // cycles per step
) (
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset
  aprs_tick_if.src t // tick out
);
  logic [aprs_pkg::STEP_W-1:0] cnt_q; // step counter
  // free-running count from the always-on clock
  always_ff @(posedge clk) begin
    if (rst || cnt_q == aprs_pkg::STEP_W'(STEP_CYC - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign t.tick = (cnt_q == aprs_pkg::STEP_W'(STEP_CYC - 1));
endmodule : aprs_tick

// ==== rtl/aprs_seq.sv ====
// sleep state sequencer with rail enables, power good and deep-well handshake
`timescale 1ns/100ps
module aprs_seq #(
  parameter int STEP_CYC = aprs_pkg::STEP_CYC // cycles per 100 ms step
) (
  input wire logic CLK, // always-on clock
  input wire logic SYS_RST, // battery-domain reset, sync high
  input wire logic SLEEP_SUSPEND_RAM_N, // sleep to ram pin
  input wire logic SLEEP_SOFT_OFF_N, // soft off pin
  input wire logic MAIN_RAIL_OK, // main rail good pin
  input wire logic DUAL_RAIL_LOW, // dual rail under 1.05V
  input wire logic SUSPEND_WARNING_N, // hub suspend warning
  input wire logic SUSPEND_WELL_SLEEP_N, // hub suspend-well sleep
  input wire logic RESUME_RESET_N, // resume reset from hub side
  input wire logic WAKE_LAN, // lan wake
  input wire logic WAKE_KBMS, // keyboard or mouse wake
  input wire logic RING_INDICATE_N, // serial ring indicator
  input wire logic MAINS_LOST, // mains power loss indication
  input wire logic [15:0] REG_ADDR, // register address
  input wire logic REG_WR, // register write strobe
  input wire logic [7:0] REG_WDATA, // write data
  output logic [7:0] REG_RDATA, // read data
  output logic CORE_RAIL_ENABLE, // core rail enable
  output logic LINK_RAIL_ENABLE, // link rail enable
  output logic POWER_GOOD_OUT, // delayed power good
  output logic RESET_CONTROL_OUT_N, // reset control
  output logic RESET_AUX_OUT_N, // second reset output
  output logic DUAL_RAIL_GATE, // 1 = dual rail from main 5V
  output logic STANDBY_CUT0_N, // cut of 5V/3.3V standby
  output logic STANDBY_CUT1_N, // cut of auxiliary 3.3V
  output logic SUSPEND_ACKNOWLEDGE_N, // ack to hub
  output logic DEEP_SLEEP_WELL_STATE, // in deep well
  output logic POWER_ON_REQ // request system power on
);
  aprs_tick_if tk (); // step tick carrier
  aprs_tick #(.STEP_CYC(STEP_CYC)) u_tick (.clk(CLK), .rst(SYS_RST), .t(tk));

  // two-flop synchronisers for the ten sleep, rail, handshake and wake pins; MAINS_LOST is used unsynchronised
  localparam int NS = 10;
  logic [NS-1:0] pin_raw; // raw pins
  logic [NS-1:0] s1_q; // first stage
  logic [NS-1:0] s2_q; // second stage
  // idle levels at reset: sleeps asserted, main rail off, dual rail not low, handshakes released, no wake
  localparam logic [NS-1:0] SYNC_RESET = 10'h039;
  assign pin_raw = {SLEEP_SUSPEND_RAM_N, SLEEP_SOFT_OFF_N, MAIN_RAIL_OK, DUAL_RAIL_LOW,
                    SUSPEND_WARNING_N, SUSPEND_WELL_SLEEP_N, RESUME_RESET_N, WAKE_LAN,
                    WAKE_KBMS, RING_INDICATE_N};
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end
  logic s3_n, s5_n, rail_ok, dual_low, warn_n, suspend_well_sleep_n_n, rsm_n, w_lan, w_kb, ri_n;
  assign {s3_n, s5_n, rail_ok, dual_low, warn_n, suspend_well_sleep_n_n, rsm_n, w_lan, w_kb, ri_n} = s2_q;

  // registers
  logic [7:0] pgd_q; // power good delay select
  logic [7:0] rsc_q; // rail sequence control
  logic lost_q; // mains loss seen, awaiting resume
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pgd_q <= aprs_pkg::PGD_RESET;
    end else if (REG_WR && REG_ADDR == aprs_pkg::OFF_PG_DELAY) begin
      pgd_q <= REG_WDATA;
    end
  end
  aprs_pkg::aprs_state_t st_q, st_d; // power state
  logic on_now;
  assign on_now = (st_q == aprs_pkg::ST_S0);
  // record on/off at loss, software writes otherwise
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rsc_q <= aprs_pkg::RSC_RESET;
    end else if (MAINS_LOST && !lost_q) begin
      rsc_q[aprs_pkg::RSC_LAST_ON] <= on_now;
    end else if (REG_WR && REG_ADDR == aprs_pkg::OFF_RAIL_CTRL) begin
      rsc_q <= REG_WDATA;
    end
  end
  // read mux; unmapped reads return zero
  always_comb begin
    unique case (REG_ADDR)
      aprs_pkg::OFF_PG_DELAY: REG_RDATA = pgd_q;
      aprs_pkg::OFF_RAIL_CTRL: REG_RDATA = rsc_q;
      default: REG_RDATA = 8'h00;
    endcase
  end

  // after-loss power-on decision on mains return
  logic [1:0] loss_mode;
  logic pon_q;
  assign loss_mode = pgd_q[aprs_pkg::PGD_LOSS_LSB +: 2];
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lost_q <= 1'b0;
      pon_q <= 1'b0;
    end else if (MAINS_LOST) begin
      lost_q <= 1'b1;
      pon_q <= 1'b0;
    end else if (lost_q) begin
      lost_q <= 1'b0;
      pon_q <= (loss_mode == aprs_pkg::LOSS_ON) ||
               (loss_mode == aprs_pkg::LOSS_KEEP && rsc_q[aprs_pkg::RSC_LAST_ON]);
    end else if (!s5_n) begin
      pon_q <= pon_q;
    end else begin
      pon_q <= 1'b0;
    end
  end
  assign POWER_ON_REQ = pon_q;

  // state machine
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      aprs_pkg::ST_S5: begin
        // leaving soft off, S3 only as transient
        if (s5_n) st_d = aprs_pkg::ST_S3T;
      end
      aprs_pkg::ST_S3T: begin
        if (!s5_n) st_d = aprs_pkg::ST_S5;
        else if (s3_n) st_d = aprs_pkg::ST_S0;
      end
      aprs_pkg::ST_S0: begin
        if (!s5_n) st_d = aprs_pkg::ST_S5;
        else if (!s3_n) st_d = aprs_pkg::ST_S3;
      end
      aprs_pkg::ST_S3: begin
        // S3 only returns to S0; S5 request ignored
        if (s3_n && s5_n) st_d = aprs_pkg::ST_S0;
        // suspend-well sleep after ack
        // a wake still present keeps the device out of deep well
        else if (!suspend_well_sleep_n_n && !SUSPEND_ACKNOWLEDGE_N && !(w_lan || w_kb || !ri_n)) begin
          st_d = aprs_pkg::ST_DSW;
        end
      end
      aprs_pkg::ST_DSW: begin
        // hub leaves deep well; extra wakes
        if (suspend_well_sleep_n_n || w_lan || w_kb || !ri_n) st_d = aprs_pkg::ST_S3;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) st_q <= aprs_pkg::ST_S5;
    else st_q <= st_d;
  end

  // acknowledge once warned and dual rail low
  logic ack_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) ack_q <= 1'b0;
    else if (warn_n) ack_q <= 1'b0;
    else if (dual_low) ack_q <= 1'b1;
  end
  assign SUSPEND_ACKNOWLEDGE_N = !ack_q;
  assign DEEP_SLEEP_WELL_STATE = (st_q == aprs_pkg::ST_DSW);

  // rail enables; bits keep a rail on in S3
  logic core_q, link_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      core_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      core_q <= on_now || (st_q == aprs_pkg::ST_S3 && rsc_q[aprs_pkg::RSC_CORE_ON_S3]);
      link_q <= on_now || (st_q == aprs_pkg::ST_S3 && rsc_q[aprs_pkg::RSC_LINK_ON_S3]);
    end
  end
  assign CORE_RAIL_ENABLE = core_q;
  assign LINK_RAIL_ENABLE = link_q;

  // power good delay in 100 ms steps
  logic [2:0] main_steps, extra_steps;
  logic [3:0] need, steps_q;
  logic pg_q;
  assign main_steps = {1'b0, pgd_q[aprs_pkg::PGD_MAIN_LSB +: 2]} + 3'h1;
  assign extra_steps = (pgd_q[aprs_pkg::PGD_EXTRA_LSB +: 2] == 2'h3) ? 3'h4 :
                       {1'b0, pgd_q[aprs_pkg::PGD_EXTRA_LSB +: 2]};
  assign need = {1'b0, main_steps} + {1'b0, extra_steps};
  always_ff @(posedge CLK) begin
    if (SYS_RST || !rail_ok || !on_now) begin
      steps_q <= 4'h0;
      pg_q <= 1'b0;
    end else if (steps_q >= need) begin
      pg_q <= 1'b1;
    end else if (tk.tick) begin
      steps_q <= steps_q + 4'h1;
    end
  end
  assign POWER_GOOD_OUT = pg_q;

  // two resets; control one optionally from power good
  logic rc_q, ra_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rc_q <= 1'b0;
      ra_q <= 1'b0;
    end else begin
      rc_q <= pgd_q[aprs_pkg::PGD_RESET_CONTROL_OUT_N_BIT] ? pg_q : rsm_n;
      ra_q <= pg_q;
    end
  end
  assign RESET_CONTROL_OUT_N = rc_q;
  assign RESET_AUX_OUT_N = ra_q;

  // gate: main only in S0 after power good
  logic gate_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) gate_q <= 1'b0;
    else if (!on_now || st_d != aprs_pkg::ST_S0) gate_q <= 1'b0;
    else if (pg_q) gate_q <= 1'b1;
  end
  assign DUAL_RAIL_GATE = gate_q;

  logic cut0_q, cut1_q, asleep;
  assign asleep = !on_now && st_q != aprs_pkg::ST_S3T;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cut0_q <= 1'b1;
      cut1_q <= 1'b1;
    end else if (st_q == aprs_pkg::ST_DSW) begin
      cut0_q <= 1'b1;
      cut1_q <= !rsc_q[aprs_pkg::RSC_KEEP_CUT1];
    end else if (asleep) begin
      cut0_q <= !rsc_q[aprs_pkg::RSC_KEEP_CUT0];
      cut1_q <= !rsc_q[aprs_pkg::RSC_KEEP_CUT1];
    end else begin
      cut0_q <= 1'b0;
      cut1_q <= 1'b0;
    end
  end
  assign STANDBY_CUT0_N = cut0_q;
  assign STANDBY_CUT1_N = cut1_q;

  no_s3_s5_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    st_q == aprs_pkg::ST_S3 |=> st_q != aprs_pkg::ST_S5) else $error("S3 to S5 taken");
  no_s5_s3_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    st_q == aprs_pkg::ST_S5 |=> st_q != aprs_pkg::ST_S3) else $error("S5 to S3 taken");
  pg_rail_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    POWER_GOOD_OUT |-> $past(rail_ok)) else $error("power good without rail");
  rst_pg_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    pgd_q[aprs_pkg::PGD_RESET_CONTROL_OUT_N_BIT] && $stable(pgd_q) |=> RESET_CONTROL_OUT_N == $past(pg_q))
    else $error("reset control not from power good");
  ack_warn_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !SUSPEND_ACKNOWLEDGE_N |-> $past(!warn_n)) else $error("ack without warning");
  dsw_cut_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    DEEP_SLEEP_WELL_STATE ##1 DEEP_SLEEP_WELL_STATE |-> STANDBY_CUT0_N)
    else $error("standby on in deep well");
  gate_s0_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    DUAL_RAIL_GATE |-> on_now) else $error("gate main outside S0");
  rails_s0_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    on_now [*2] |-> CORE_RAIL_ENABLE && LINK_RAIL_ENABLE) else $error("rails off in S0");
  c_s0_c: cover property (@(posedge CLK) st_q == aprs_pkg::ST_S0);
  c_dsw_c: cover property (@(posedge CLK) DEEP_SLEEP_WELL_STATE);
  c_pg_c: cover property (@(posedge CLK) POWER_GOOD_OUT);
endmodule : aprs_seq

// ==== verification/aprs_hub_model.sv ====
// chipset hub model driving the sleep levels and the deep-well handshake
`timescale 1ns/100ps
module aprs_hub_model (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic want_s3_n, // bench asks for suspend to ram
  input wire logic want_s5_n, // bench asks for soft off
  input wire logic want_dsw, // bench asks for deep well
  input wire logic ack_n, // device acknowledge
  output logic s3_n, // sleep to ram level
  output logic s5_n, // soft off level
  output logic warn_n, // suspend warning
  output logic sus_n, // suspend-well sleep
  output logic rsm_n, // resume reset
  output logic dual_low // dual rail below threshold
);
  // sleep levels follow the bench request
  always_ff @(posedge clk) begin
    s3_n <= !rst && want_s3_n;
    s5_n <= !rst && want_s5_n;
  end
  always_ff @(posedge clk) begin
    if (rst || (!want_dsw && rsm_n && sus_n)) warn_n <= 1'b1;
    else if (want_dsw) warn_n <= 1'b0;
    dual_low <= !rst && !warn_n;
  end
  // suspend sleep after ack, resume reset after suspend sleep
  always_ff @(posedge clk) begin
    if (rst || !want_dsw) sus_n <= 1'b1;
    else if (!ack_n) sus_n <= 1'b0;
    if (rst || (sus_n && !want_dsw)) rsm_n <= 1'b1;
    else if (!sus_n) rsm_n <= 1'b0;
  end
endmodule : aprs_hub_model

// ==== verification/testbench.sv ====
// self-checking bench for the power rail sequencer
`timescale 1ns/100ps
module testbench;
  localparam int STEP = 10; // shortened delay step
  localparam logic [15:0] PGD = aprs_pkg::OFF_PG_DELAY; // delay select
  localparam logic [15:0] RSC = aprs_pkg::OFF_RAIL_CTRL; // rail control
  logic clk = 1'b0, rst = 1'b1, rail_ok = 1'b0, wl = 1'b0, wk = 1'b0, ri_n = 1'b1;
  logic lost = 1'b0, wr = 1'b0, w3_n = 1'b0, w5_n = 1'b0, deep_sleep_well_state = 1'b0;
  logic [15:0] addr = 16'h0000; // register address
  logic [7:0] wd = 8'h00, rd; // register data
  logic s3_n, s5_n, warn_n, sus_n, rsm_n, dlow, core, link, pg, rc_n, ra_n, gate;
  logic c0_n, c1_n, ack_n, dsw_st, on_req; // cuts, handshake, state
  int failures = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  aprs_seq #(.STEP_CYC(STEP)) aprs_seq_i (.CLK(clk), .SYS_RST(rst),
    .SLEEP_SUSPEND_RAM_N(s3_n), .SLEEP_SOFT_OFF_N(s5_n), .MAIN_RAIL_OK(rail_ok),
    .DUAL_RAIL_LOW(dlow), .SUSPEND_WARNING_N(warn_n), .SUSPEND_WELL_SLEEP_N(sus_n),
    .RESUME_RESET_N(rsm_n), .WAKE_LAN(wl), .WAKE_KBMS(wk), .RING_INDICATE_N(ri_n),
    .MAINS_LOST(lost), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wd), .REG_RDATA(rd),
    .CORE_RAIL_ENABLE(core), .LINK_RAIL_ENABLE(link), .POWER_GOOD_OUT(pg),
    .RESET_CONTROL_OUT_N(rc_n), .RESET_AUX_OUT_N(ra_n), .DUAL_RAIL_GATE(gate),
    .STANDBY_CUT0_N(c0_n), .STANDBY_CUT1_N(c1_n), .SUSPEND_ACKNOWLEDGE_N(ack_n),
    .DEEP_SLEEP_WELL_STATE(dsw_st), .POWER_ON_REQ(on_req));
  aprs_hub_model aprs_hub_model_i (.clk(clk), .rst(rst), .want_s3_n(w3_n),
    .want_s5_n(w5_n), .want_dsw(deep_sleep_well_state), .ack_n(ack_n), .s3_n(s3_n), .s5_n(s5_n),
    .warn_n(warn_n), .sus_n(sus_n), .rsm_n(rsm_n), .dual_low(dlow));
  // one counted comparison
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // wait edges, then settle
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // register write, one strobe cycle
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // register read against expectation
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    cyc(1);
    chk("register", e, rd);
  endtask : rreg
  // mains loss pulse
  task automatic lose;
    @(posedge clk) lost <= 1'b1;
    @(posedge clk) lost <= 1'b0;
    cyc(3);
  endtask : lose
  // reset values, access, unmapped place
  task automatic t_regs;
    rreg(PGD, 8'h03);
    rreg(RSC, 8'h00);
    chk("cuts", 2'b11, {c0_n, c1_n});
    wreg(PGD, 8'h55);
    wreg(RSC, 8'h0f);
    wreg(16'h0af6, 8'hff);
    rreg(PGD, 8'h55);
    rreg(RSC, 8'h0f);
    rreg(16'h0af6, 8'h00);
    wreg(PGD, 8'h03);
    wreg(RSC, 8'h00);
  endtask : t_regs
  // soft off to working, gate waits for main rail
  task automatic t_on;
    @(posedge clk) w5_n <= 1'b1;
    cyc(4);
    @(posedge clk) w3_n <= 1'b1;
    cyc(8);
    chk("rails", 2'b11, {core, link});
    chk("gate", 0, gate);
    @(posedge clk) rail_ok <= 1'b1;
    cyc(50);
    chk("gate", 1, gate);
  endtask : t_on
  // power good delay for one setting of s steps
  task automatic t_pg(input logic [7:0] v, input int s);
    wreg(PGD, v);
    @(posedge clk) rail_ok <= 1'b0;
    cyc(5);
    chk("pg", 0, pg);
    chk("reset_control_out_n", !v[4], rc_n);
    @(posedge clk) rail_ok <= 1'b1;
    for (n = 0; n < 100 && pg !== 1'b1; n++) cyc(1);
    chk("pg_delay", 1, n >= (s - 1) * STEP + 2 && n <= s * STEP + 6);
    cyc(2);
    chk("resets", 2'b11, {ra_n, rc_n});
  endtask : t_pg
  // suspend to ram, refused soft off, return
  task automatic t_sleep(input logic [7:0] v, input logic [3:0] e);
    wreg(RSC, v);
    @(posedge clk) w3_n <= 1'b0;
    cyc(6);
    chk("sleep", e, {core, link, c0_n, c1_n});
    chk("gate", 0, gate);
    @(posedge clk) rail_ok <= 1'b0;
    @(posedge clk) w5_n <= 1'b0;
    cyc(6);
    chk("sleep", e, {core, link, c0_n, c1_n});
    @(posedge clk) w5_n <= 1'b1;
    cyc(2);
    @(posedge clk) w3_n <= 1'b1;
    cyc(6);
    chk("gate", 0, gate);
    @(posedge clk) rail_ok <= 1'b1;
    cyc(60);
    chk("gate", 1, gate);
  endtask : t_sleep
  // deep well entry, wake by source w, hub exit
  task automatic t_dsw(input int w);
    wreg(RSC, 8'h04);
    @(posedge clk) w3_n <= 1'b0;
    cyc(6);
    chk("cut0", 0, c0_n);
    @(posedge clk) deep_sleep_well_state <= 1'b1;
    for (n = 0; n < 30 && ack_n !== 1'b0; n++) cyc(1);
    chk("ack", 0, ack_n);
    for (n = 0; n < 30 && dsw_st !== 1'b1; n++) cyc(1);
    cyc(1);
    chk("dsw_cut0", 2'b11, {dsw_st, c0_n});
    @(posedge clk);
    wl <= (w == 0);
    wk <= (w == 1);
    ri_n <= (w != 2);
    cyc(5);
    chk("dsw", 0, dsw_st);
    @(posedge clk) deep_sleep_well_state <= 1'b0;
    for (n = 0; n < 40 && ack_n !== 1'b1; n++) cyc(1);
    chk("ack", 1, ack_n);
    @(posedge clk);
    wl <= 1'b0;
    wk <= 1'b0;
    ri_n <= 1'b1;
    @(posedge clk) w3_n <= 1'b1;
    cyc(6);
  endtask : t_dsw
  // after-loss modes
  task automatic t_loss;
    wreg(RSC, 8'h00);
    wreg(PGD, 8'h43);
    @(posedge clk);
    w3_n <= 1'b0;
    w5_n <= 1'b0;
    lose();
    cyc(3);
    chk("on_req", 1, on_req);
    rreg(RSC, 8'h10);
    wreg(PGD, 8'h03);
    lose();
    chk("on_req", 0, on_req);
    wreg(PGD, 8'h23);
    lose();
    chk("on_req", 1, on_req);
  endtask : t_loss
  // verdict and end of run
  task automatic results;
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_on();
    t_pg(8'h00, 1);
    t_pg(8'h01, 2);
    t_pg(8'h02, 3);
    t_pg(8'h03, 4);
    t_pg(8'h04, 2);
    t_pg(8'h08, 3);
    t_pg(8'h1c, 5);
    t_sleep(8'h00, 4'b0011);
    t_sleep(8'h05, 4'b1001);
    t_sleep(8'h0a, 4'b0110);
    for (int i = 0; i < 3; i++) t_dsw(i);
    t_loss();
    results();
  end
  // watchdog against a hang
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule : testbench
